// *** dv/adc_seq_assertions.sv ***
// checker for the sequencer control slice, bound to its top module
// assumes it sees only the top ports, one clock domain
`timescale 1ns/10ps
`default_nettype none

module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic conv_done,
    input wire logic [3:0] sample_hold_enable,
    input wire logic conv_irq,
    input wire logic dma_addr_inc,
    input wire logic buffer_half_status,
    input wire chsel_t ch123_select,
    input wire logic ch123_neg_vrefl_a,
    input wire logic ch123_neg_vrefl_b
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_event_excl;
        !(conv_irq && dma_addr_inc);
    endproperty
    property p_irq_cause;
        conv_irq |-> ($past(clk_en) ? $past(conv_done) : $past(conv_irq));
    endproperty
    property p_dma_cause;
        dma_addr_inc |-> ($past(clk_en) ? $past(conv_done) : $past(dma_addr_inc));
    endproperty
    property p_half_rise;
        $rose(buffer_half_status) |-> (conv_irq || dma_addr_inc);
    endproperty
    property p_enable_set;
        sample_hold_enable inside {4'h1, 4'h3, 4'hf};
    endproperty
    property p_vrefl_a;
        ch123_neg_vrefl_a == !ch123_select.neg_a[1];
    endproperty
    property p_vrefl_b;
        ch123_neg_vrefl_b == !ch123_select.neg_b[1];
    endproperty
    property p_read_hold;
        !$past(hsel && htrans[1] && !hwrite && hready && clk_en) |-> $stable(hrdata);
    endproperty

    a_event_excl: assert property (p_event_excl)
        else $error("irq and dma events together");
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without a completed conversion");
    a_dma_cause: assert property (p_dma_cause)
        else $error("dma advance without a completed conversion");
    a_half_rise: assert property (p_half_rise)
        else $error("half status rose outside a group end");
    a_enable_set: assert property (p_enable_set)
        else $error("illegal channel enable pattern");
    a_vrefl_a: assert property (p_vrefl_a)
        else $error("set a low reference flag wrong");
    a_vrefl_b: assert property (p_vrefl_b)
        else $error("set b low reference flag wrong");
    a_read_hold: assert property (p_read_hold)
        else $error("read data moved without a read");

    // main scenarios reached
    c_irq: cover property (conv_irq);
    c_dma: cover property (dma_addr_inc);
    c_half: cover property ($rose(buffer_half_status));
endmodule

bind adc_sequence_channel_control adc_seq_checker u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .conv_done(conv_done), .sample_hold_enable(sample_hold_enable),
    .conv_irq(conv_irq), .dma_addr_inc(dma_addr_inc),
    .buffer_half_status(buffer_half_status), .ch123_select(ch123_select),
    .ch123_neg_vrefl_a(ch123_neg_vrefl_a), .ch123_neg_vrefl_b(ch123_neg_vrefl_b)
);
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the sequencer control slice
// assumes the slice is the only ahb-lite slave; clk_en drops only in the freeze test
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module tb_top import adc_seq_pkg::*;;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic ref_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, conv_done = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, conv_irq, dma_addr_inc, buffer_half_status;
    logic ch123_neg_vrefl_a, ch123_neg_vrefl_b, exp_half = 1'h0, clk_en = 1'h1;
    logic [3:0] sample_hold_enable;
    logic [3:0] en_tab [4] = '{4'h1, 4'h3, 4'hf, 4'hf};
    chsel_t ch123_select;
    int err_count = 0, checks_done = 0, irq_n = 0, dma_n = 0;

    always #25 ref_clk = ~ref_clk;

    // event pulse tallies
    always @(posedge ref_clk) begin
        irq_n <= irq_n + int'(conv_irq);
        dma_n <= dma_n + int'(dma_addr_inc);
    end

    adc_sequence_channel_control DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
        .sample_hold_enable(sample_hold_enable), .conv_irq(conv_irq),
        .dma_addr_inc(dma_addr_inc), .buffer_half_status(buffer_half_status),
        .ch123_select(ch123_select), .ch123_neg_vrefl_a(ch123_neg_vrefl_a),
        .ch123_neg_vrefl_b(ch123_neg_vrefl_b)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one single ahb-lite transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'h1;
        haddr <= {24'h0, ofs};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'h1) @(posedge ref_clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'h1) @(posedge ref_clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        ahb(1'h1, ofs, d);
    endtask

    task automatic rchk(input string n, input logic [7:0] ofs, input logic [31:0] exp);
        ahb(1'h0, ofs, 32'h0);
        chk(n, rd, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // k back-to-back completed conversions
    task automatic burst(input int k);
        repeat (k) begin
            @(posedge ref_clk);
            conv_done <= 1'h1;
        end
        @(posedge ref_clk);
        conv_done <= 1'h0;
        settle;
    endtask

    // one full group with split on: nothing before the nth, one event at it
    task automatic group(input logic dma, input logic [4:0] rate, input int n);
        int i0;
        int d0;
        wr(`OFS_CONVERTER_CFG, {30'h0, dma, 1'h0});
        wr(`OFS_CONTROL_TWO, {25'h0, rate, 2'h2});
        i0 = irq_n;
        d0 = dma_n;
        burst(n - 1);
        chk("early event", irq_n + dma_n - i0 - d0, 0);
        rchk("group count", `OFS_SEQ_STATUS, n - 1);
        burst(1);
        chk("irq count", irq_n - i0, dma ? 0 : 1);
        chk("dma count", dma_n - d0, dma ? 1 : 0);
        exp_half = ~exp_half;
        chk("half status", buffer_half_status, exp_half);
        rchk("half bit", `OFS_CONTROL_TWO, {24'h0, exp_half, rate, 2'h2});
        $display("test group n=%0d dma=%0d done", n, dma);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'h0;
        rchk("ctrl reset", `OFS_CONTROL_TWO, 32'h0);
        rchk("select reset", `OFS_CH123_SELECT, 32'h0);
        rchk("unmapped", 8'h10, 32'h0);
        chk("enable reset", sample_hold_enable, 4'h1);
        chk("okay response", hresp, 1'h0);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_CONTROL_TWO, {22'h0, c[1:0], 8'h0});
            settle;
            chk("enable", sample_hold_enable, en_tab[c]);
            rchk("count field", `OFS_CONTROL_TWO, {22'h0, c[1:0], 8'h0});
        end
        $display("test channel count done");
        wr(`OFS_CH123_SELECT, 32'hffff_ffff);
        settle;
        chk("select all", ch123_select, 6'h3f);
        chk("vrefl a off", ch123_neg_vrefl_a, 1'h0);
        rchk("select read", `OFS_CH123_SELECT, 32'h0000_0707);
        wr(`OFS_CH123_SELECT, 32'h0000_0403);
        settle;
        chk("select mix", ch123_select, 6'h23);
        chk("vrefl a on", ch123_neg_vrefl_a, 1'h1);
        chk("vrefl b off", ch123_neg_vrefl_b, 1'h0);
        $display("test input select done");
        wr(`OFS_CONVERTER_CFG, 32'h1);
        settle;
        chk("enable 12b", sample_hold_enable, 4'h1);
        rchk("count 12b", `OFS_CONTROL_TWO, 32'h0);
        rchk("select 12b", `OFS_CH123_SELECT, 32'h0);
        chk("select out 12b", ch123_select, 6'h0);
        wr(`OFS_CH123_SELECT, 32'h0000_0101);
        wr(`OFS_CONTROL_TWO, 32'h0000_0100);
        rchk("count wr 12b", `OFS_CONTROL_TWO, 32'h0);
        wr(`OFS_CONVERTER_CFG, 32'h0);
        rchk("select kept", `OFS_CH123_SELECT, 32'h0000_0403);
        rchk("count kept", `OFS_CONTROL_TWO, 32'h0000_0300);
        $display("test 12-bit mode done");
        // frozen clock enable: conversions ignored, bus stalled
        @(posedge ref_clk);
        clk_en <= 1'h0;
        burst(3);
        chk("freeze irq", irq_n, 0);
        chk("freeze ready", hreadyout, 1'h0);
        @(posedge ref_clk);
        clk_en <= 1'h1;
        rchk("freeze count", `OFS_SEQ_STATUS, 32'h0);
        $display("test freeze done");
        group(1'h0, 5'h12, 3);
        group(1'h1, 5'h12, 19);
        group(1'h0, 5'h1f, 16);
        group(1'h1, 5'h1f, 32);
        group(1'h0, 5'h00, 1);
        print_verdict;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        print_verdict;
    end
endmodule
`default_nettype wire

// *** src/adc_seq_defs.svh ***
// constants for the sequencer control slice: offsets, field positions, resets
// assumes a 32-bit AHB-Lite bus with word-aligned registers
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_TWO 8'h00
`define OFS_CONVERTER_CFG 8'h04
`define OFS_CH123_SELECT 8'h08
`define OFS_SEQ_STATUS 8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CNT_SEL_HI 9
`define CNT_SEL_LO 8
`define HALF_STAT_BIT 7
`define RATE_HI 6
`define RATE_LO 2
`define SPLIT_BIT 1
`define CFG_RES12_BIT 0
`define CFG_DMA_BIT 1
`define NEG_B_HI 10
`define NEG_B_LO 9
`define POS_B_BIT 8
`define NEG_A_HI 2
`define NEG_A_LO 1
`define POS_A_BIT 0
`define STAT_CNT_HI 4
`define STAT_CNT_LO 0

// ----------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------
`define RST_CNT_SEL 2'h0
`define RST_RATE 5'h00
`define RST_SH_EN 4'h1
`define RST_VREFL 1'b1
`define RST_CNT 5'h00
`define RST_CHSEL 6'h00
`define RST_HRDATA 32'h0000_0000
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// *** src/adc_seq_pkg.sv ***
// types shared by the sequencer control slice
// assumes adc_seq_defs.svh for numeric constants
package adc_seq_pkg;

    // register write request from the bus port
    typedef struct packed {
        logic en;
        logic [7:0] ofs;
        logic [31:0] data;
    } reg_wr_t;

    // register read request in the address phase
    typedef struct packed {
        logic en;
        logic [7:0] ofs;
    } reg_rd_t;

    // channel 1-3 input selection for both mux sets
    typedef struct packed {
        logic [1:0] neg_b;
        logic pos_b;
        logic [1:0] neg_a;
        logic pos_a;
    } chsel_t;

    // bus port phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_WRITE = 2'b10
    } ahb_phase_t;

endpackage

// *** src/adc_sequence_channel_control.sv ***
// top of the converter sequencer control slice: registers, channel enables,
// input selection and conversion event pacing
// assumes ahb-lite master on ref_clk, conv_done from the converter core
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_sequence_channel_control
    import adc_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic conv_done,
    output logic [3:0] sample_hold_enable,
    output logic conv_irq,
    output logic dma_addr_inc,
    output logic buffer_half_status,
    output chsel_t ch123_select,
    output logic ch123_neg_vrefl_a,
    output logic ch123_neg_vrefl_b
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg_wr_t wr;
    reg_rd_t rd;
    logic [31:0] rd_data;
    logic [1:0] channel_count_select_q;
    logic [4:0] conversions_per_event_q;
    logic buffer_split_mode_q;
    logic resolution_12bit_select_q;
    logic dma_addressing_enable_q;
    chsel_t chsel_q;
    chsel_t chsel_vis;
    logic [1:0] count_sel_vis;
    logic [3:0] sh_enable_d;
    logic [3:0] sh_enable_q;
    chsel_t chsel_out_q;
    logic vrefl_a_q;
    logic vrefl_b_q;
    logic [4:0] group_count;
    logic half;
    logic irq_p;
    logic dma_p;
    logic wr_ctl2;
    logic wr_cfg;
    logic wr_sel;

    // ------------------------------------------------------------
    // bus port
    // ------------------------------------------------------------
    ahb_reg_port u_port (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .rd_data(rd_data),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr(wr),
        .rd(rd)
    );

    // write decode; only whole words are issued, hsize is not needed
    assign wr_ctl2 = wr.en & (wr.ofs == `OFS_CONTROL_TWO);
    assign wr_cfg = wr.en & (wr.ofs == `OFS_CONVERTER_CFG);
    assign wr_sel = wr.en & (wr.ofs == `OFS_CH123_SELECT);

    // ------------------------------------------------------------
    // converter configuration register
    // ------------------------------------------------------------

    // resolution and dma addressing mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resolution_12bit_select_q <= 1'b0;
            dma_addressing_enable_q <= 1'b0;
        end else if (clk_en & wr_cfg) begin
            resolution_12bit_select_q <= wr.data[`CFG_RES12_BIT];
            dma_addressing_enable_q <= wr.data[`CFG_DMA_BIT];
        end
    end

    // ------------------------------------------------------------
    // control two register
    // ------------------------------------------------------------

    // channel count: writes dropped in 12-bit mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_count_select_q <= `RST_CNT_SEL;
        end else if (clk_en & wr_ctl2 & ~resolution_12bit_select_q) begin
            channel_count_select_q <= wr.data[`CNT_SEL_HI:`CNT_SEL_LO];
        end
    end

    // increment rate and buffer split mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conversions_per_event_q <= `RST_RATE;
            buffer_split_mode_q <= 1'b0;
        end else if (clk_en & wr_ctl2) begin
            conversions_per_event_q <= wr.data[`RATE_HI:`RATE_LO];
            buffer_split_mode_q <= wr.data[`SPLIT_BIT];
        end
    end

    // channel count as seen by software and the sequencer
    assign count_sel_vis = resolution_12bit_select_q ? `RST_CNT_SEL : channel_count_select_q;

    // ------------------------------------------------------------
    // channel 1-3 input select register
    // ------------------------------------------------------------

    // both mux set fields at their bit positions
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chsel_q <= `RST_CHSEL;
        end else if (clk_en & wr_sel & ~resolution_12bit_select_q) begin
            chsel_q.neg_b <= wr.data[`NEG_B_HI:`NEG_B_LO];
            chsel_q.pos_b <= wr.data[`POS_B_BIT];
            chsel_q.neg_a <= wr.data[`NEG_A_HI:`NEG_A_LO];
            chsel_q.pos_a <= wr.data[`POS_A_BIT];
        end
    end

    // fields vanish in 12-bit mode, only channel 0 converts there
    assign chsel_vis = resolution_12bit_select_q ? `RST_CHSEL : chsel_q;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------

    // unmapped offsets and reserved bits read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd.ofs)
            `OFS_CONTROL_TWO: begin
                rd_data[`CNT_SEL_HI:`CNT_SEL_LO] = count_sel_vis;
                rd_data[`HALF_STAT_BIT] = half;
                rd_data[`RATE_HI:`RATE_LO] = conversions_per_event_q;
                rd_data[`SPLIT_BIT] = buffer_split_mode_q;
            end
            `OFS_CONVERTER_CFG: begin
                rd_data[`CFG_RES12_BIT] = resolution_12bit_select_q;
                rd_data[`CFG_DMA_BIT] = dma_addressing_enable_q;
            end
            `OFS_CH123_SELECT: begin
                rd_data[`NEG_B_HI:`NEG_B_LO] = chsel_vis.neg_b;
                rd_data[`POS_B_BIT] = chsel_vis.pos_b;
                rd_data[`NEG_A_HI:`NEG_A_LO] = chsel_vis.neg_a;
                rd_data[`POS_A_BIT] = chsel_vis.pos_a;
            end
            `OFS_SEQ_STATUS: begin
                rd_data[`STAT_CNT_HI:`STAT_CNT_LO] = group_count;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sample-and-hold channel enables
    // ------------------------------------------------------------

    // channels converted per sample from the count select
    always_comb begin
        sh_enable_d = 4'h1;
        case (count_sel_vis)
            2'h0: sh_enable_d = 4'h1;
            2'h1: sh_enable_d = 4'h3;
            2'h2, 2'h3: sh_enable_d = 4'hf;
            default: sh_enable_d = 4'h1;
        endcase
    end

    // registered enables toward the converter core
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_enable_q <= `RST_SH_EN;
        end else if (clk_en) begin
            sh_enable_q <= sh_enable_d;
        end
    end

    assign sample_hold_enable = sh_enable_q;

    // ------------------------------------------------------------
    // input mux steering
    // ------------------------------------------------------------

    // select fields and low-reference flags toward the analog mux
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chsel_out_q <= `RST_CHSEL;
            vrefl_a_q <= `RST_VREFL;
            vrefl_b_q <= `RST_VREFL;
        end else if (clk_en) begin
            chsel_out_q <= chsel_vis;
            vrefl_a_q <= ~chsel_vis.neg_a[1];
            vrefl_b_q <= ~chsel_vis.neg_b[1];
        end
    end

    assign ch123_select = chsel_out_q;
    assign ch123_neg_vrefl_a = vrefl_a_q;
    assign ch123_neg_vrefl_b = vrefl_b_q;

    // ------------------------------------------------------------
    // conversion event pacing and buffer half
    // ------------------------------------------------------------
    sample_event_counter u_events (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .conv_done(conv_done),
        .dma_en(dma_addressing_enable_q),
        .split_en(buffer_split_mode_q),
        .rate(conversions_per_event_q),
        .irq_pulse(irq_p),
        .dma_pulse(dma_p),
        .half_q(half),
        .count(group_count)
    );

    // event outputs and half status straight from flops
    assign conv_irq = irq_p;
    assign dma_addr_inc = dma_p;
    assign buffer_half_status = half;

endmodule
`default_nettype wire

// *** src/ahb_reg_port.sv ***
// ahb-lite slave front end: turns transfers into register read/write requests
// assumes one slave on the bus, single word transfers; wait states only while clk_en is low
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module ahb_reg_port
    import adc_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] rd_data,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output reg_wr_t wr,
    output reg_rd_t rd
);

    ahb_phase_t phase_q;
    logic [7:0] wofs_q;
    logic [31:0] hrdata_q;
    logic take;

    // address phase accepted; frozen clock enable stalls the bus
    assign take = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready & clk_en;
    assign hreadyout = clk_en;
    assign hresp = `HRESP_OKAY;
    assign rd.en = take & ~hwrite;
    assign rd.ofs = haddr[7:0];

    // write data phase follows an accepted write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= PH_IDLE;
            wofs_q <= 8'h00;
        end else if (clk_en) begin
            case (phase_q)
                PH_IDLE, PH_WRITE: begin
                    phase_q <= (take & hwrite) ? PH_WRITE : PH_IDLE;
                    wofs_q <= haddr[7:0];
                end
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    assign wr.en = (phase_q == PH_WRITE) & clk_en;
    assign wr.ofs = wofs_q;
    assign wr.data = hwdata;

    // read data captured at the address phase edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= `RST_HRDATA;
        end else if (rd.en) begin
            hrdata_q <= rd_data;
        end
    end

    assign hrdata = hrdata_q;

endmodule
`default_nettype wire

// *** src/sample_event_counter.sv ***
// counts completed conversions and fires interrupt or dma address events
// assumes conv_done is a one-cycle pulse per sample/conversion operation
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module sample_event_counter (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic conv_done,
    input wire logic dma_en,
    input wire logic split_en,
    input wire logic [4:0] rate,
    output logic irq_pulse,
    output logic dma_pulse,
    output logic half_q,
    output logic [4:0] count
);

    logic [4:0] cnt_q;
    logic [4:0] limit;
    logic last;

    // dma uses all five bits, interrupts only the low four
    assign limit = dma_en ? rate : {1'b0, rate[3:0]};
    assign last = (cnt_q >= limit);
    assign count = cnt_q;

    // conversion count within the current group
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= `RST_CNT;
        end else if (clk_en & conv_done) begin
            cnt_q <= last ? `RST_CNT : cnt_q + 5'h01;
        end
    end

    // one event per completed group
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_pulse <= 1'b0;
            dma_pulse <= 1'b0;
        end else if (clk_en) begin
            irq_pulse <= conv_done & last & ~dma_en;
            dma_pulse <= conv_done & last & dma_en;
        end
    end

    // half in use flips at each group end while split; first half after reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_q <= 1'b0;
        end else if (clk_en) begin
            if (!split_en) begin
                half_q <= 1'b0;
            end else if (conv_done & last) begin
                half_q <= ~half_q;
            end
        end
    end

endmodule
`default_nettype wire
